/* hw/pcm_pkg.sv */
// pcm_pkg: constants and state type for the port C pin-function mux
package pcm_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] PCM_DIR_OFF = 4'h0;
  localparam logic [3:0] PCM_DATA_OFF = 4'h4;
  localparam logic [3:0] PCM_PIN_OFF = 4'h8;
  localparam logic [3:0] PCM_STAT_OFF = 4'hc;
  localparam int PCM_AW = 4;
  // field layout: port C in bits 7..0, port B bit 0 in bit 8
  localparam int PCM_NPIN = 8;
  localparam int PCM_PB0_BIT = 8;
  localparam int PCM_CLAIM_LSB = 16;
  // reset values
  localparam logic [8:0] PCM_DIR_RST = 9'h000;
  localparam logic [8:0] PCM_DATA_RST = 9'h000;
  localparam logic [31:0] PCM_ZERO32 = 32'h0000_0000;
  // prescaler codes that pick an external clock pin
  localparam logic [2:0] PCM_PSC_CLK_D = 3'h7;
  localparam logic [2:0] PCM_PSC_CLK_C = 3'h6;
  localparam logic [2:0] PCM_PSC_CLK_B = 3'h5;
  localparam logic [2:0] PCM_PSC_CLK_A = 3'h4;
  // I/O control pattern 10xx: upper two bits
  localparam logic [1:0] PCM_IO_IN_PAT = 2'h2;
  localparam int PCM_IO_W = 4;
  // htrans NONSEQ marker bit
  localparam int PCM_HTRANS_ACT = 1;
  // ext clock vector bit order
  localparam int PCM_CLK_A = 0;
  localparam int PCM_CLK_B = 1;
  localparam int PCM_CLK_C = 2;
  localparam int PCM_CLK_D = 3;

  typedef struct packed {
    logic [PCM_AW-1:0] addr;
    logic wr_pend;
    logic [8:0] dir;
    logic [8:0] dout;
    logic [31:0] hrdata;
    logic [7:0] claim;
    logic [7:0] pc_out;
    logic [7:0] pc_oe;
    logic pb_out;
    logic pb_oe;
    logic [7:0] wake_n;
    logic [7:0] cap;
    logic [3:0] ext_clk;
    logic [8:0] pin_in;
    logic ready;
    logic resp;
  } pcm_state_t;
endpackage : pcm_pkg

/* hw/pcm_port_c_mux.sv */
// pcm_port_c_mux: pin-function mux for port C and port B bit 0, AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module pcm_port_c_mux (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic [7:0] portc_pin_in,
  output logic [7:0] portc_pin_out,
  output logic [7:0] portc_pin_oe,
  input wire logic portb0_pin_in,
  output logic portb0_pin_out,
  output logic portb0_pin_oe,
  // host interface
  input wire logic host_smi_output_enable,
  input wire logic host_smi_output,
  // timer unit, pin-ordered (bit 7 = ch2 b ... bit 0 = ch0 a)
  input wire logic [7:0] tmr_pin_out_en,
  input wire logic [7:0] tmr_cc_out,
  input wire logic [31:0] tmr_io_ctl,
  input wire logic [2:0] tmr_normal_mode,
  input wire logic [2:0] tmr_phase_mode,
  input wire logic [2:0] tmr_psc_ch0,
  input wire logic [2:0] tmr_psc_ch1,
  input wire logic [2:0] tmr_psc_ch2,
  output logic [7:0] tmr_cap_in,
  output logic [3:0] tmr_ext_clk,
  // interrupt controller
  input wire logic [7:0] wakeup_mask,
  output logic [7:0] wakeup_input_n
);
  import pcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // per-pin capture gating
  // channel owning each pin, and whether only bit 3 of the field is tested
  localparam logic [15:0] PIN_CH = 16'ha500;
  localparam logic [7:0] PIN_BIT3 = 8'hc0;

  logic [7:0] cap_sel;
  genvar gi;
  generate
    for (gi = 0; gi < PCM_NPIN; gi++) begin : g_cap
      localparam int CH = int'(PIN_CH[2*gi +: 2]);
      logic [PCM_IO_W-1:0] fld;
      logic io_ok;
      assign fld = tmr_io_ctl[PCM_IO_W*gi +: PCM_IO_W];
      // channel 2 looks at bit 3 only; channels 0 and 1 want 10xx
      assign io_ok = PIN_BIT3[gi] ? fld[PCM_IO_W-1]
                                  : (fld[PCM_IO_W-1 -: 2] == PCM_IO_IN_PAT);
      assign cap_sel[gi] = tmr_normal_mode[CH] | (tmr_phase_mode[CH] & io_ok);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // external clock selection
  logic [3:0] clk_sel;
  always_comb begin
    clk_sel[PCM_CLK_D] = (tmr_psc_ch0 == PCM_PSC_CLK_D) | tmr_phase_mode[2];
    clk_sel[PCM_CLK_C] = (tmr_psc_ch0 == PCM_PSC_CLK_C) | (tmr_psc_ch2 == PCM_PSC_CLK_C)
                       | tmr_phase_mode[1];
    clk_sel[PCM_CLK_B] = (tmr_psc_ch0 == PCM_PSC_CLK_B) | (tmr_psc_ch1 == PCM_PSC_CLK_B)
                       | (tmr_psc_ch2 == PCM_PSC_CLK_B) | tmr_phase_mode[0];
    clk_sel[PCM_CLK_A] = (tmr_psc_ch0 == PCM_PSC_CLK_A) | (tmr_psc_ch1 == PCM_PSC_CLK_A)
                       | (tmr_psc_ch2 == PCM_PSC_CLK_A) | tmr_phase_mode[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  pcm_state_t s;
  pcm_state_t next_s;
  logic addr_ok;
  logic [8:0] oe_now;

  assign addr_ok = hsel & htrans[PCM_HTRANS_ACT] & hready;

  always_comb begin
    next_s = s;
    oe_now = '0;
    // data phase of a write; zero wait states, so no stall path exists
    next_s.wr_pend = 1'b0;
    if (s.wr_pend) begin
      unique case (s.addr)
        PCM_DIR_OFF: next_s.dir = hwdata[8:0];
        PCM_DATA_OFF: next_s.dout = hwdata[8:0];
        default: ;
      endcase
    end
    // pin routing uses the freshly written settings
    for (int i = 0; i < PCM_NPIN; i++) begin
      if (tmr_pin_out_en[i]) begin
        next_s.pc_out[i] = tmr_cc_out[i];
        next_s.pc_oe[i] = 1'b1;
      end else begin
        next_s.pc_out[i] = next_s.dout[i];
        next_s.pc_oe[i] = next_s.dir[i];
      end
      // inputs are tapped in parallel so none hides another
      next_s.wake_n[i] = wakeup_mask[i] | portc_pin_in[i];
      next_s.cap[i] = cap_sel[i] & portc_pin_in[i];
    end
    next_s.ext_clk[PCM_CLK_D] = clk_sel[PCM_CLK_D] & portc_pin_in[7];
    next_s.ext_clk[PCM_CLK_C] = clk_sel[PCM_CLK_C] & portc_pin_in[5];
    next_s.ext_clk[PCM_CLK_B] = clk_sel[PCM_CLK_B] & portc_pin_in[3];
    next_s.ext_clk[PCM_CLK_A] = clk_sel[PCM_CLK_A] & portc_pin_in[2];
    if (host_smi_output_enable) begin
      next_s.pb_out = host_smi_output;
      next_s.pb_oe = 1'b1;
    end else begin
      next_s.pb_out = next_s.dout[PCM_PB0_BIT];
      next_s.pb_oe = next_s.dir[PCM_PB0_BIT];
    end
    next_s.pin_in = {portb0_pin_in, portc_pin_in};
    next_s.claim = tmr_pin_out_en;
    // zero wait states, so the answer is always ready and okay
    next_s.ready = 1'b1;
    next_s.resp = 1'b0;
    oe_now = {s.pb_oe, s.pc_oe};
    // address phase: latch target, prepare read data; dir and data from updated regs, pins and status from registered state
    if (addr_ok) begin
      next_s.addr = haddr[PCM_AW-1:0];
      next_s.wr_pend = hwrite & (haddr[31:PCM_AW] == '0);
      next_s.hrdata = PCM_ZERO32;
      if (!hwrite && haddr[31:PCM_AW] == '0) begin
        unique case (haddr[PCM_AW-1:0])
          PCM_DIR_OFF: next_s.hrdata[8:0] = next_s.dir;
          PCM_DATA_OFF: next_s.hrdata[8:0] = next_s.dout;
          PCM_PIN_OFF: next_s.hrdata[8:0] = s.pin_in;
          PCM_STAT_OFF: begin
            next_s.hrdata[8:0] = oe_now;
            next_s.hrdata[PCM_CLAIM_LSB +: PCM_NPIN] = s.claim;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{addr: '0, wr_pend: 1'b0, dir: PCM_DIR_RST, dout: PCM_DATA_RST,
             hrdata: PCM_ZERO32, claim: 8'h00, pc_out: 8'h00, pc_oe: 8'h00,
             pb_out: 1'b0, pb_oe: 1'b0, wake_n: 8'hff, cap: 8'h00,
             ext_clk: 4'h0, pin_in: 9'h000, ready: 1'b1, resp: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.ready;
  assign hresp = s.resp;
  assign portc_pin_out = s.pc_out;
  assign portc_pin_oe = s.pc_oe;
  assign portb0_pin_out = s.pb_out;
  assign portb0_pin_oe = s.pb_oe;
  assign tmr_cap_in = s.cap;
  assign tmr_ext_clk = s.ext_clk;
  assign wakeup_input_n = s.wake_n;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_smi_override: assert property (host_smi_output_enable |=>
      portb0_pin_oe && portb0_pin_out == $past(host_smi_output))
    else $error("smi enable did not take port b bit 0");

  a_pb0_gpio_dir: assert property (!host_smi_output_enable |=>
      portb0_pin_oe == s.dir[PCM_PB0_BIT])
    else $error("port b bit 0 direction not followed");

  a_gpio_dir: assert property (tmr_pin_out_en == 8'h00 |=>
      portc_pin_oe == s.dir[7:0] && portc_pin_out == s.dout[7:0])
    else $error("port c gpio direction not followed");

  a_timer_claim: assert property (tmr_pin_out_en == 8'hff |=>
      portc_pin_oe == 8'hff && portc_pin_out == $past(tmr_cc_out))
    else $error("timer output did not claim port c");

  a_wake_route: assert property (wakeup_mask == 8'h00 ##1 wakeup_mask == 8'h00 |->
      wakeup_input_n == $past(portc_pin_in))
    else $error("unmasked wake-up input lost the pin level");

  a_wake_masked: assert property (wakeup_mask == 8'hff |=> wakeup_input_n == 8'hff)
    else $error("masked wake-up input not idle");

  a_clk_d_phase: assert property (tmr_phase_mode[2] |=>
      tmr_ext_clk[PCM_CLK_D] == $past(portc_pin_in[7]))
    else $error("clock d not fed in phase counting");

  a_clk_c_psc2: assert property (tmr_psc_ch2 == PCM_PSC_CLK_C |=>
      tmr_ext_clk[PCM_CLK_C] == $past(portc_pin_in[5]))
    else $error("clock c not fed for prescaler 110");

  a_clk_b_psc1: assert property (tmr_psc_ch1 == PCM_PSC_CLK_B |=>
      tmr_ext_clk[PCM_CLK_B] == $past(portc_pin_in[3]))
    else $error("clock b not fed for prescaler 101");

  a_clk_a_off: assert property (tmr_psc_ch0 == 3'h0 && tmr_psc_ch1 == 3'h0
      && tmr_psc_ch2 == 3'h0 && !tmr_phase_mode[0] |=> !tmr_ext_clk[PCM_CLK_A])
    else $error("clock a driven while not selected");

  a_cap_ch2_gate: assert property (tmr_phase_mode[2] && !tmr_normal_mode[2]
      && !tmr_io_ctl[31] && !tmr_io_ctl[27] |=> tmr_cap_in[7:6] == 2'h0)
    else $error("channel 2 capture fed without bit 3");

  a_cap_ch0_pat: assert property (tmr_phase_mode[0] && !tmr_normal_mode[0]
      && tmr_io_ctl[15:0] == 16'h8888 |=> tmr_cap_in[3:0] == $past(portc_pin_in[3:0]))
    else $error("channel 0 capture not fed for 10xx");

  a_cap_ch1_norm: assert property (tmr_normal_mode[1] |=>
      tmr_cap_in[5:4] == $past(portc_pin_in[5:4]))
    else $error("channel 1 capture not fed in normal mode");

  a_all_inputs: assert property (tmr_phase_mode[2] && tmr_io_ctl[31]
      && !wakeup_mask[7] |=> tmr_cap_in[7] == $past(portc_pin_in[7])
      && tmr_ext_clk[PCM_CLK_D] == $past(portc_pin_in[7])
      && wakeup_input_n[7] == $past(portc_pin_in[7]))
    else $error("alternate inputs on bit 7 disagree");

  ////////////////////////////////////////////////////////////////////////
  // bus and register checks
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");

  a_dir_write: assert property (s.wr_pend && s.addr == PCM_DIR_OFF |=>
      s.dir == $past(hwdata[8:0]))
    else $error("direction write did not land");

  a_data_write: assert property (s.wr_pend && s.addr == PCM_DATA_OFF |=>
      s.dout == $past(hwdata[8:0]))
    else $error("data write did not land");

  a_ro_write: assert property (s.wr_pend && s.addr == PCM_PIN_OFF |=>
      s.dir == $past(s.dir) && s.dout == $past(s.dout))
    else $error("write to the pin register changed the settings");

  a_rd_dir: assert property (addr_ok && !hwrite && haddr == 32'(PCM_DIR_OFF) |=>
      hrdata == {23'h00_0000, s.dir})
    else $error("direction read does not match the register");

  a_rd_unmapped: assert property (addr_ok && !hwrite && haddr[31:PCM_AW] != '0 |=>
      hrdata == PCM_ZERO32)
    else $error("unmapped read returned data");

  a_rd_pins: assert property (addr_ok && !hwrite && haddr == 32'(PCM_PIN_OFF) |=>
      hrdata[8:0] == $past({portb0_pin_in, portc_pin_in}, 2))
    else $error("pin read does not show the sampled levels");

  a_rd_hold: assert property (!addr_ok |=> $stable(hrdata))
    else $error("read data moved outside an address phase");

  a_rd_stat: assert property (addr_ok && !hwrite
      && haddr == 32'(PCM_STAT_OFF) |=> hrdata[8:0] == $past({portb0_pin_oe, portc_pin_oe})
      && hrdata[PCM_CLAIM_LSB +: PCM_NPIN] == $past(tmr_pin_out_en, 2))
    else $error("status read does not show enables and claims");

  ////////////////////////////////////////////////////////////////////////
  // port b and external clock checks
  a_pb0_gpio_out: assert property (!host_smi_output_enable |=>
      portb0_pin_out == s.dout[PCM_PB0_BIT])
    else $error("port b bit 0 output value not followed");

  a_clk_d_psc0: assert property (tmr_psc_ch0 == PCM_PSC_CLK_D |=>
      tmr_ext_clk[PCM_CLK_D] == $past(portc_pin_in[7]))
    else $error("clock d not fed for prescaler 111");

  a_clk_d_off: assert property (tmr_psc_ch0 != PCM_PSC_CLK_D && !tmr_phase_mode[2] |=>
      !tmr_ext_clk[PCM_CLK_D])
    else $error("clock d driven while not selected");

  a_clk_c_psc0: assert property (tmr_psc_ch0 == PCM_PSC_CLK_C |=>
      tmr_ext_clk[PCM_CLK_C] == $past(portc_pin_in[5]))
    else $error("clock c not fed for channel 0 prescaler");

  a_clk_c_phase: assert property (tmr_phase_mode[1] |=>
      tmr_ext_clk[PCM_CLK_C] == $past(portc_pin_in[5]))
    else $error("clock c not fed in phase counting");

  a_clk_c_off: assert property (tmr_psc_ch0 != PCM_PSC_CLK_C && tmr_psc_ch2 != PCM_PSC_CLK_C
      && !tmr_phase_mode[1] |=> !tmr_ext_clk[PCM_CLK_C])
    else $error("clock c driven while not selected");

  a_clk_b_phase: assert property (tmr_phase_mode[0] |=>
      tmr_ext_clk[PCM_CLK_B] == $past(portc_pin_in[3])
      && tmr_ext_clk[PCM_CLK_A] == $past(portc_pin_in[2]))
    else $error("clocks a and b not fed in phase counting");

  a_clk_b_off: assert property (tmr_psc_ch0 != PCM_PSC_CLK_B
      && tmr_psc_ch1 != PCM_PSC_CLK_B && tmr_psc_ch2 != PCM_PSC_CLK_B
      && !tmr_phase_mode[0] |=> !tmr_ext_clk[PCM_CLK_B])
    else $error("clock b driven while not selected");

  a_clk_a_psc: assert property (tmr_psc_ch0 == PCM_PSC_CLK_A
      || tmr_psc_ch1 == PCM_PSC_CLK_A || tmr_psc_ch2 == PCM_PSC_CLK_A
      |=> tmr_ext_clk[PCM_CLK_A] == $past(portc_pin_in[2]))
    else $error("clock a not fed for prescaler 100");

  ////////////////////////////////////////////////////////////////////////
  // capture input checks
  a_cap_ch2_bit3: assert property (tmr_phase_mode[2] && tmr_io_ctl[31] && tmr_io_ctl[27] |=>
      tmr_cap_in[7:6] == $past(portc_pin_in[7:6]))
    else $error("channel 2 capture not fed with bit 3 set");

  a_cap_ch2_norm: assert property (tmr_normal_mode[2] |=>
      tmr_cap_in[7:6] == $past(portc_pin_in[7:6]))
    else $error("channel 2 capture not fed in normal mode");

  a_cap_ch1_pat: assert property (tmr_phase_mode[1] && tmr_io_ctl[23:16] == 8'h88 |=>
      tmr_cap_in[5:4] == $past(portc_pin_in[5:4]))
    else $error("channel 1 capture not fed for 10xx");

  a_cap_ch1_off: assert property (!tmr_normal_mode[1] && tmr_io_ctl[23:22] != PCM_IO_IN_PAT
      && tmr_io_ctl[19:18] != PCM_IO_IN_PAT |=> tmr_cap_in[5:4] == 2'h0)
    else $error("channel 1 capture fed without 10xx");

  a_cap_ch0_norm: assert property (tmr_normal_mode[0] |=>
      tmr_cap_in[3:0] == $past(portc_pin_in[3:0]))
    else $error("channel 0 capture not fed in normal mode");

  a_cap_ch0_off: assert property (!tmr_normal_mode[0] && !tmr_phase_mode[0] |=>
      tmr_cap_in[3:0] == 4'h0)
    else $error("channel 0 capture fed while idle");

  ////////////////////////////////////////////////////////////////////////
  // per-pin checks
  generate
    for (gi = 0; gi < PCM_NPIN; gi++) begin : g_chk
      a_pin_claim: assert property (tmr_pin_out_en[gi] |=>
          portc_pin_oe[gi] && portc_pin_out[gi] == $past(tmr_cc_out[gi]))
        else $error("timer output lost its pin");
      a_pin_gpio: assert property (!tmr_pin_out_en[gi] |=>
          portc_pin_oe[gi] == s.dir[gi] && portc_pin_out[gi] == s.dout[gi])
        else $error("free pin ignored its direction bit");
      a_pin_wake: assert property (!wakeup_mask[gi] |=>
          wakeup_input_n[gi] == $past(portc_pin_in[gi]))
        else $error("unmasked pin did not reach its wake-up input");
      a_pin_masked: assert property (wakeup_mask[gi] |=> wakeup_input_n[gi])
        else $error("masked wake-up input went active");
    end
  endgenerate

  c_smi_on: cover property (host_smi_output_enable ##1 !host_smi_output_enable);
  c_dir_write: cover property (s.wr_pend && s.addr == PCM_DIR_OFF);
  c_three_taps: cover property (wakeup_mask[5] == 1'b0 && cap_sel[5] && clk_sel[PCM_CLK_C]);
  c_claim_all: cover property (tmr_pin_out_en == 8'hff);
  c_rd_stat: cover property (addr_ok && !hwrite && haddr == 32'(PCM_STAT_OFF));
endmodule : pcm_port_c_mux
`default_nettype wire

/* verification/pcm_far_model.sv */
// pcm_far_model: timer unit, interrupt controller and host interface seen by the mux
`timescale 1ns/1ps
`default_nettype none
module pcm_far_model (
  // timer unit
  output logic [7:0] pin_out_en,
  output logic [7:0] cc_out,
  output logic [31:0] io_ctl,
  output logic [2:0] normal_mode,
  output logic [2:0] phase_mode,
  output logic [2:0] psc0,
  output logic [2:0] psc1,
  output logic [2:0] psc2,
  // interrupt controller and host interface
  output logic [7:0] wake_mask,
  output logic smi_en,
  output logic smi_out
);
  // settings move only by non-blocking update, called at a clock edge
  task set_out(input logic [7:0] en, input logic [7:0] val);
    pin_out_en <= en;
    cc_out <= val;
  endtask : set_out
  task set_mode(input logic [31:0] ioc, input logic [2:0] nrm, input logic [2:0] ph);
    io_ctl <= ioc;
    normal_mode <= nrm;
    phase_mode <= ph;
  endtask : set_mode
  task set_psc(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
    psc0 <= a;
    psc1 <= b;
    psc2 <= c;
  endtask : set_psc
  task set_host(input logic [7:0] msk, input logic en, input logic val);
    wake_mask <= msk;
    smi_en <= en;
    smi_out <= val;
  endtask : set_host
  // all wake-up inputs masked at start, as out of reset
  initial begin
    set_out(8'h00, 8'h00);
    set_mode(32'h0000_0000, 3'h0, 3'h0);
    set_psc(3'h0, 3'h0, 3'h0);
    set_host(8'hff, 1'b0, 1'b0);
  end
endmodule : pcm_far_model
`default_nettype wire

/* verification/pcm_port_c_mux_tb.sv */
// pcm_port_c_mux_tb: bus tasks and pin routing scenarios for the port C mux
`timescale 1ns/1ps
`default_nettype none
module pcm_port_c_mux_tb;
  import pcm_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic pb_in, pb_out, pb_oe, smi_en, smi_out;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, ioc, rv;
  logic [7:0] pc_in, pc_out, pc_oe, oen, cc, cap, wake_n, msk;
  logic [2:0] nrm, ph, p0, p1, p2;
  logic [3:0] eclk;
  // {psc0, psc1, psc2, phase, expected clocks}
  logic [15:0] ctab [14] = '{16'h8001, 16'ha002, 16'hc004, 16'he008, 16'h0304, 16'h0282,
    16'h1001, 16'h1c00, 16'h1800, 16'h0380, 16'h0013, 16'h0024, 16'h0048, 16'h1402};
  int num_errors, checks_done, i;
  ////////////////////////////////////////
  pcm_port_c_mux pcm_port_c_mux_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .portc_pin_in(pc_in), .portc_pin_out(pc_out), .portc_pin_oe(pc_oe),
    .portb0_pin_in(pb_in), .portb0_pin_out(pb_out), .portb0_pin_oe(pb_oe),
    .host_smi_output_enable(smi_en), .host_smi_output(smi_out), .tmr_pin_out_en(oen),
    .tmr_cc_out(cc), .tmr_io_ctl(ioc), .tmr_normal_mode(nrm), .tmr_phase_mode(ph),
    .tmr_psc_ch0(p0), .tmr_psc_ch1(p1), .tmr_psc_ch2(p2), .tmr_cap_in(cap),
    .tmr_ext_clk(eclk), .wakeup_mask(msk), .wakeup_input_n(wake_n));
  pcm_far_model pcm_far_model_i (.pin_out_en(oen), .cc_out(cc), .io_ctl(ioc),
    .normal_mode(nrm), .phase_mode(ph), .psc0(p0), .psc1(p1), .psc2(p2),
    .wake_mask(msk), .smi_en(smi_en), .smi_out(smi_out));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  ////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // a stuck slave would hang the bus, so give up after 51 edges
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        test_done;
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rv = hrdata;
  endtask : bus
  // outputs follow inputs one edge late; look one edge after that
  task settle;
    repeat (2) @(posedge hclk);
  endtask : settle
  ////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    pc_in = 8'h00;
    pb_in = 1'b0;
    num_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    chk(32'(wake_n), 32'h0000_00ff);
    chk(32'(pc_oe), 32'h0000_0000);
    chk(32'({hreadyout, hresp}), 32'h0000_0002);
    $display("reset test done");
    bus(1'b1, 32'(PCM_DIR_OFF), 32'h0000_01f0);
    bus(1'b1, 32'(PCM_DATA_OFF), 32'h0000_01a5);
    settle;
    chk(32'({pb_oe, pc_oe}), 32'h0000_01f0);
    chk(32'({pb_out, pc_out & pc_oe}), 32'h0000_01a0);
    bus(1'b0, 32'(PCM_DIR_OFF), 32'h0000_0000);
    chk(rv, 32'h0000_01f0);
    pc_in <= 8'h3c;
    pb_in <= 1'b1;
    bus(1'b1, 32'(PCM_PIN_OFF), 32'hffff_ffff);
    bus(1'b0, 32'(PCM_PIN_OFF), 32'h0000_0000);
    chk(rv, 32'h0000_013c);
    bus(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk(rv, 32'h0000_0000);
    $display("direction test done");
    pcm_far_model_i.set_host(8'hff, 1'b1, 1'b0);
    settle;
    chk(32'({pb_oe, pb_out}), 32'h0000_0002);
    pcm_far_model_i.set_host(8'hff, 1'b0, 1'b0);
    bus(1'b1, 32'(PCM_DIR_OFF), 32'h0000_0000);
    settle;
    chk(32'({pb_oe, pc_oe}), 32'h0000_0000);
    $display("smi test done");
    pcm_far_model_i.set_out(8'hff, 8'h5a);
    settle;
    chk(32'({pc_oe, pc_out}), 32'h0000_ff5a);
    pcm_far_model_i.set_out(8'h30, 8'h10);
    settle;
    chk(32'({pc_oe, pc_out & 8'h30}), 32'h0000_3010);
    bus(1'b0, 32'(PCM_STAT_OFF), 32'h0000_0000);
    chk(rv, 32'h0030_0030);
    $display("timer output test done");
    pcm_far_model_i.set_host(8'h0f, 1'b0, 1'b0);
    pcm_far_model_i.set_mode(32'h0000_0000, 3'h7, 3'h0);
    pc_in <= 8'h55;
    settle;
    chk(32'({wake_n, cap}), 32'h0000_5f55);
    pc_in <= 8'ha5;
    pcm_far_model_i.set_mode(32'h0000_0000, 3'h0, 3'h7);
    settle;
    chk(32'(cap), 32'h0000_0000);
    pcm_far_model_i.set_mode(32'h8888_8888, 3'h0, 3'h7);
    settle;
    chk(32'(cap), 32'h0000_00a5);
    pcm_far_model_i.set_mode(32'hcccc_cccc, 3'h0, 3'h7);
    settle;
    chk(32'(cap), 32'h0000_0080);
    pcm_far_model_i.set_mode(32'h8888_8888, 3'h1, 3'h2);
    settle;
    chk(32'(cap), 32'h0000_0025);
    pcm_far_model_i.set_host(8'h00, 1'b0, 1'b0);
    pc_in <= 8'h96;
    settle;
    chk(32'(wake_n), 32'h0000_0096);
    $display("capture test done");
    pc_in <= 8'hff;
    for (i = 0; i < 14; i++) begin
      pcm_far_model_i.set_psc(ctab[i][15:13], ctab[i][12:10], ctab[i][9:7]);
      pcm_far_model_i.set_mode(32'h0000_0000, 3'h0, ctab[i][6:4]);
      settle;
      chk(32'(eclk), 32'(ctab[i][3:0]));
    end
    pc_in <= 8'h00;
    settle;
    chk(32'(eclk), 32'h0000_0000);
    $display("clock test done");
    test_done;
  end
endmodule : pcm_port_c_mux_tb
`default_nettype wire
